// File: design/mcr_pkg.sv
package mcr_pkg;
  // ==========================================================================
  // Register map: printed offsets are word indices, byte address is 4 * index.
  localparam logic [5:0]  MIC_IDX        = 6'h07;
  localparam logic [5:0]  MISC_IDX       = 6'h08;
  localparam logic [5:0]  DAC1_REQ_IDX   = 6'h09;
  localparam logic [5:0]  DAC2_REQ_IDX   = 6'h0A;
  localparam logic [5:0]  STATUS_IDX     = 6'h0B;
  // ==========================================================================
  // Field layout and reset values.
  localparam int          GAIN_W         = 5;
  localparam int          L_MUTE_BIT     = 15;
  localparam int          L_GAIN_LSB     = 8;
  localparam int          R_MUTE_BIT     = 7;
  localparam int          R_GAIN_LSB     = 0;
  localparam int          GLOBAL_BIT     = 7;
  localparam int          MONO_OUT_BIT   = 6;
  localparam int          HP_MUTE_BIT    = 5;
  localparam int          HP_SWING_BIT   = 4;
  localparam int          SUM_MUTE_BIT   = 3;
  localparam int          FIRST_DAC_GAIN_TIMING_BIT      = 0;
  localparam logic [15:0] MIC_RST        = 16'h8888;
  localparam logic [15:0] MISC_RST       = 16'h8868;
  localparam logic [15:0] MIC_WMASK      = 16'h9F9F;
  localparam logic [15:0] MISC_WMASK     = 16'h9FFB;
  localparam logic [15:0] DAC_REQ_RST    = 16'h0808;
  // ==========================================================================
  // Timing: shortest edge of the 10 to 12 ms deferral window.
  localparam int          TIMEOUT_US     = 10000;
  localparam int          CLK_FREQ_MHZ   = 250;
  localparam int          TIMEOUT_CYC    = TIMEOUT_US * CLK_FREQ_MHZ;
  // ==========================================================================
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_WRITE  = 2'b01,
    BUS_RDWAIT = 2'b11,
    BUS_RDDATA = 2'b10
  } mcr_bus_t;

  typedef struct packed {
    logic              left_mic_mix_mute;
    logic [GAIN_W-1:0] left_mic_mix_gain;
    logic              right_mic_mix_mute;
    logic [GAIN_W-1:0] right_mic_mix_gain;
    logic              mono_in_mix_mute;
    logic [GAIN_W-1:0] mono_in_mix_gain;
    logic              global_mix_mute;
    logic              mono_out_mute;
    logic              headphone_mute;
    logic              headphone_swing_select;
    logic              summing_input_mute;
  } mcr_mix_t;
endpackage

// File: design/mcr_gain_if.sv
`timescale 1ns/1ps
interface mcr_gain_if;
  logic        req_valid;
  logic [15:0] req_gain;
  logic        immediate;
  logic        zero_cross;
  logic [15:0] applied;
  logic        pending;
  modport ctrl  (output req_valid, req_gain, immediate, zero_cross,
                 input  applied, pending);
  modport defer (input  req_valid, req_gain, immediate, zero_cross,
                 output applied, pending);
endinterface

// File: design/mcr_gain_defer.sv
`timescale 1ns/1ps
module mcr_gain_defer import mcr_pkg::*; #(
  parameter int          TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [15:0] GAIN_RST       = DAC_REQ_RST
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  mcr_gain_if.defer gif
);
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  logic [15:0]      applied_r;
  logic [15:0]      held_r;
  logic             pending_r;
  logic [CNT_W-1:0] cnt_r;

  assign gif.applied = applied_r;
  assign gif.pending = pending_r;

  // A newer request replaces a held one and restarts the timeout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_r <= GAIN_RST;
      held_r    <= GAIN_RST;
      pending_r <= 1'b0;
      cnt_r     <= '0;
    end else if (gif.req_valid) begin
      held_r    <= gif.req_gain;
      cnt_r     <= '0;
      pending_r <= !gif.immediate;
      if (gif.immediate) begin
        applied_r <= gif.req_gain;
      end
    end else if (pending_r) begin
      if (gif.immediate || gif.zero_cross || cnt_r == CNT_LAST) begin
        applied_r <= held_r;
        pending_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// File: design/mcr_mix_decode.sv
`timescale 1ns/1ps
module mcr_mix_decode import mcr_pkg::*; (
  input  wire logic [15:0] mic_word,
  input  wire logic [15:0] misc_word,
  output mcr_mix_t         mix
);
  logic global_w;

  assign global_w = misc_word[GLOBAL_BIT];

  always_comb begin
    mix.global_mix_mute        = global_w;
    mix.left_mic_mix_mute      = mic_word[L_MUTE_BIT] | global_w;
    mix.left_mic_mix_gain      = mic_word[L_GAIN_LSB +: GAIN_W];
    mix.right_mic_mix_mute     = mic_word[R_MUTE_BIT] | global_w;
    mix.right_mic_mix_gain     = mic_word[R_GAIN_LSB +: GAIN_W];
    mix.mono_in_mix_mute       = misc_word[L_MUTE_BIT] | global_w;
    mix.mono_in_mix_gain       = misc_word[L_GAIN_LSB +: GAIN_W];
    mix.mono_out_mute          = misc_word[MONO_OUT_BIT];
    mix.headphone_mute         = misc_word[HP_MUTE_BIT];
    mix.headphone_swing_select = misc_word[HP_SWING_BIT];
    mix.summing_input_mute     = misc_word[SUM_MUTE_BIT] | global_w;
  end
endmodule

// File: design/mcr_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - Microphone register bit 15 mutes the left mic mix path when set.
// - Microphone bits 12..8 hold left mic mix gain, -1.5 dB per step.
// - Microphone register bit 7 mutes the right mic mix path when set.
// - Microphone bits 4..0 hold right mic mix gain, same coding as left.
// - Microphone register resets to 0x8888: both muted, both at 0 dB.
// - Microphone register held at default under reset, power-down or disables.
// - Misc bit 15 mutes mono input mix; bits 12..8 hold its gain.
// - Misc register resets to 0x8868.
// - Whole misc register held at default under reset, power-down pin, or PDN bit.
// - Misc upper byte also held while mix or analog channel enable is low.
// - Misc bit 0 set applies first DAC gain at once, else deferred.
// - Misc bit 1 does the same for the second DAC gain.
// - Misc bit 3 mutes the summing inputs mix into the first DAC.
// - Misc bit 7 mutes every mix path, overriding individual mutes.
// - Misc bit 4 selects headphone swing: 0 for 2 Vpp, 1 for 4 Vpp.
// - Misc bit 5 mutes headphones, bit 6 mutes mono output.
// - Mono mix gain uses -1.5 dB steps from +12.0 dB down.
module mcr_top import mcr_pkg::*; #(
  parameter int ADDR_W         = 8,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              powerdown_pin_n,
  input  wire logic              global_conversion_powerdown,
  input  wire logic              analog_mix_enable,
  input  wire logic              analog_channels_enable,
  input  wire logic [1:0]        dac_zero_cross,
  output logic                   left_mic_mix_mute,
  output logic [GAIN_W-1:0]      left_mic_mix_gain,
  output logic                   right_mic_mix_mute,
  output logic [GAIN_W-1:0]      right_mic_mix_gain,
  output logic                   mono_in_mix_mute,
  output logic [GAIN_W-1:0]      mono_in_mix_gain,
  output logic                   global_mix_mute,
  output logic                   mono_out_mute,
  output logic                   headphone_mute,
  output logic                   headphone_swing_select,
  output logic                   summing_input_mute,
  output logic [15:0]            dac1_gain,
  output logic [15:0]            dac2_gain,
  output logic [1:0]             dac_gain_pending
);
  // ==========================================================================
  // Declarations.
  mcr_bus_t          state_r;
  mcr_bus_t          state_nxt;
  logic [5:0]        idx_r;
  logic              mapped_r;
  logic              accept_w;
  logic              hreadyout_r;
  logic [31:0]       hrdata_r;
  logic [31:0]       rd_nxt;
  logic              wr_en_w;
  logic [15:0]       wdata_w;
  logic [15:0]       mic_r;
  logic [15:0]       misc_r;
  logic              mic_hold_w;
  logic              misc_hold_w;
  logic              upper_hold_w;
  logic [15:0]       dac_req_r [2];
  logic [1:0]        dac_req_pulse_r;
  logic [1:0]        pending_w;
  logic [15:0]       applied_w [2];
  mcr_mix_t          mix_w;
  mcr_mix_t          mix_r;

  mcr_gain_if gif [2] ();

  // ==========================================================================
  // Bus slave. Writes finish with no wait state; reads insert one wait
  // state so that a write in the preceding data phase is always visible.
  assign accept_w = hsel && htrans[1] && hready;
  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BUS_IDLE, BUS_WRITE, BUS_RDDATA: begin
        if (accept_w) begin
          state_nxt = hwrite ? BUS_WRITE : BUS_RDWAIT;
        end else begin
          state_nxt = BUS_IDLE;
        end
      end
      BUS_RDWAIT: begin
        state_nxt = BUS_RDDATA;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r    <= '0;
      mapped_r <= 1'b0;
    end else if (accept_w) begin
      idx_r    <= haddr[7:2];
      mapped_r <= (haddr[ADDR_W-1:0] == {haddr[7:2], 2'b00}) &&
                  (haddr[31:ADDR_W] == '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= (state_nxt != BUS_RDWAIT);
    end
  end

  assign wr_en_w = (state_r == BUS_WRITE) && mapped_r;
  assign wdata_w = hwdata[15:0];

  // ==========================================================================
  // Read mux. Unmapped and reserved bits read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (mapped_r) begin
      unique case (idx_r)
        MIC_IDX:      rd_nxt = {16'h0000, mic_r};
        MISC_IDX:     rd_nxt = {16'h0000, misc_r};
        DAC1_REQ_IDX: rd_nxt = {16'h0000, dac_req_r[0]};
        DAC2_REQ_IDX: rd_nxt = {16'h0000, dac_req_r[1]};
        STATUS_IDX:   rd_nxt = {30'h0000_0000, pending_w};
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (state_r == BUS_RDWAIT) begin
      hrdata_r <= rd_nxt;
    end
  end

  // ==========================================================================
  // Hold conditions. The reset pin is hresetn itself; the others force
  // the fields back to default on every clock for as long as they last.
  assign misc_hold_w  = !powerdown_pin_n || global_conversion_powerdown;
  assign upper_hold_w = !analog_mix_enable || !analog_channels_enable;
  assign mic_hold_w   = misc_hold_w || upper_hold_w;

  // ==========================================================================
  // Microphone mix register. Reserved bits are masked so they always
  // read back as zero even if software breaks the write-zero convention.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mic_r <= MIC_RST;
    end else if (mic_hold_w) begin
      mic_r <= MIC_RST;
    end else if (wr_en_w && idx_r == MIC_IDX) begin
      mic_r <= wdata_w & MIC_WMASK;
    end
  end

  // ==========================================================================
  // Mono mix and miscellaneous register. The lower byte keeps working
  // while only the analog enables are low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_r <= MISC_RST;
    end else if (misc_hold_w) begin
      misc_r <= MISC_RST;
    end else begin
      if (upper_hold_w) begin
        misc_r[15:8] <= MISC_RST[15:8];
      end else if (wr_en_w && idx_r == MISC_IDX) begin
        misc_r[15:8] <= wdata_w[15:8] & MISC_WMASK[15:8];
      end
      if (wr_en_w && idx_r == MISC_IDX) begin
        misc_r[7:0] <= wdata_w[7:0] & MISC_WMASK[7:0];
      end
    end
  end

  // ==========================================================================
  // DAC gain requests. Each write raises a one-cycle request toward the
  // deferral unit, which decides when the new gain reaches the DAC.
  for (genvar i = 0; i < 2; i++) begin : g_dac
    localparam logic [5:0] REQ_IDX = (i == 0) ? DAC1_REQ_IDX : DAC2_REQ_IDX;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dac_req_r[i]       <= DAC_REQ_RST;
        dac_req_pulse_r[i] <= 1'b0;
      end else begin
        dac_req_pulse_r[i] <= wr_en_w && idx_r == REQ_IDX;
        if (wr_en_w && idx_r == REQ_IDX) begin
          dac_req_r[i] <= wdata_w;
        end
      end
    end

    assign gif[i].req_valid  = dac_req_pulse_r[i];
    assign gif[i].req_gain   = dac_req_r[i];
    assign gif[i].immediate  = misc_r[FIRST_DAC_GAIN_TIMING_BIT + i];
    assign gif[i].zero_cross = dac_zero_cross[i];
    assign pending_w[i]      = gif[i].pending;
    assign applied_w[i]      = gif[i].applied;

    mcr_gain_defer #(
      .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
      .GAIN_RST       (DAC_REQ_RST)
    ) u_defer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .gif     (gif[i])
    );
  end

  // ==========================================================================
  // Mix field decode; outputs are registered so every mix pin leaves a flop.
  mcr_mix_decode u_decode (
    .mic_word  (mic_r),
    .misc_word (misc_r),
    .mix       (mix_w)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mix_r <= '{left_mic_mix_mute:      MIC_RST[L_MUTE_BIT],
                 left_mic_mix_gain:      MIC_RST[L_GAIN_LSB +: GAIN_W],
                 right_mic_mix_mute:     MIC_RST[R_MUTE_BIT],
                 right_mic_mix_gain:     MIC_RST[R_GAIN_LSB +: GAIN_W],
                 mono_in_mix_mute:       MISC_RST[L_MUTE_BIT],
                 mono_in_mix_gain:       MISC_RST[L_GAIN_LSB +: GAIN_W],
                 global_mix_mute:        MISC_RST[GLOBAL_BIT],
                 mono_out_mute:          MISC_RST[MONO_OUT_BIT],
                 headphone_mute:         MISC_RST[HP_MUTE_BIT],
                 headphone_swing_select: MISC_RST[HP_SWING_BIT],
                 summing_input_mute:     MISC_RST[SUM_MUTE_BIT]};
    end else begin
      mix_r <= mix_w;
    end
  end

  assign left_mic_mix_mute      = mix_r.left_mic_mix_mute;
  assign left_mic_mix_gain      = mix_r.left_mic_mix_gain;
  assign right_mic_mix_mute     = mix_r.right_mic_mix_mute;
  assign right_mic_mix_gain     = mix_r.right_mic_mix_gain;
  assign mono_in_mix_mute       = mix_r.mono_in_mix_mute;
  assign mono_in_mix_gain       = mix_r.mono_in_mix_gain;
  assign global_mix_mute        = mix_r.global_mix_mute;
  assign mono_out_mute          = mix_r.mono_out_mute;
  assign headphone_mute         = mix_r.headphone_mute;
  assign headphone_swing_select = mix_r.headphone_swing_select;
  assign summing_input_mute     = mix_r.summing_input_mute;

  // Applied gains and pending flags come from flops inside the deferral units.
  assign dac1_gain        = applied_w[0];
  assign dac2_gain        = applied_w[1];
  assign dac_gain_pending = pending_w;
endmodule

// File: verif/mcr_top_checker.sv
`timescale 1ns/1ps
module mcr_top_checker import mcr_pkg::*; #(
  parameter int TIMEOUT_CYCLES = 20
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              powerdown_pin_n,
  input wire logic              analog_mix_enable,
  input wire logic [1:0]        dac_zero_cross,
  input wire logic              left_mic_mix_mute,
  input wire logic [GAIN_W-1:0] left_mic_mix_gain,
  input wire logic              right_mic_mix_mute,
  input wire logic [GAIN_W-1:0] right_mic_mix_gain,
  input wire logic              mono_in_mix_mute,
  input wire logic [GAIN_W-1:0] mono_in_mix_gain,
  input wire logic              global_mix_mute,
  input wire logic              summing_input_mute,
  input wire logic [1:0]        dac_gain_pending
);
  // Timeout lands near TIMEOUT_CYCLES+1 after the request; a few cycles of slack.
  localparam int TMO_MAX = TIMEOUT_CYCLES + 4;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pin_held; (!powerdown_pin_n)[*3]; endsequence
  sequence s_mix_held; (!analog_mix_enable)[*3]; endsequence
  property p_gl_left; global_mix_mute |-> left_mic_mix_mute; endproperty
  property p_gl_right; global_mix_mute |-> right_mic_mix_mute; endproperty
  property p_gl_sum; global_mix_mute |-> summing_input_mute; endproperty
  property p_gl_mono; global_mix_mute |-> mono_in_mix_mute; endproperty
  property p_mic_hold;
    s_pin_held |-> left_mic_mix_mute && right_mic_mix_mute &&
      left_mic_mix_gain == 5'h08 && right_mic_mix_gain == 5'h08;
  endproperty
  property p_misc_hold;
    s_mix_held |-> mono_in_mix_mute && mono_in_mix_gain == 5'h08;
  endproperty
  property p_zc; dac_gain_pending[0] && dac_zero_cross[0] |-> ##[1:2] !dac_gain_pending[0];
  endproperty
  property p_tmo; $rose(dac_gain_pending[1]) |-> ##[1:TMO_MAX] !dac_gain_pending[1];
  endproperty
  a_gl_left: assert property (p_gl_left) else $error("left mute not forced");
  a_gl_right: assert property (p_gl_right) else $error("right mute not forced");
  a_gl_sum: assert property (p_gl_sum) else $error("summing mute not forced");
  a_gl_mono: assert property (p_gl_mono) else $error("mono in mute not forced");
  a_mic_hold: assert property (p_mic_hold) else $error("mic fields not default");
  a_misc_hold: assert property (p_misc_hold) else $error("mono fields not default");
  a_zc: assert property (p_zc) else $error("zero crossing did not apply gain");
  a_tmo: assert property (p_tmo) else $error("deferred gain never timed out");
endmodule
bind mcr_top mcr_top_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_mcr_top_checker (
  .hclk(hclk), .hresetn(hresetn), .powerdown_pin_n(powerdown_pin_n),
  .analog_mix_enable(analog_mix_enable), .dac_zero_cross(dac_zero_cross),
  .left_mic_mix_mute(left_mic_mix_mute), .left_mic_mix_gain(left_mic_mix_gain),
  .right_mic_mix_mute(right_mic_mix_mute), .right_mic_mix_gain(right_mic_mix_gain),
  .mono_in_mix_mute(mono_in_mix_mute), .mono_in_mix_gain(mono_in_mix_gain),
  .global_mix_mute(global_mix_mute), .summing_input_mute(summing_input_mute),
  .dac_gain_pending(dac_gain_pending));

// File: verif/mcr_top_test.sv
`timescale 1ns/1ps
module mcr_top_test import mcr_pkg::*;;
  localparam int          TMO    = 20;
  localparam logic [31:0] MIC_A  = {24'h000000, MIC_IDX, 2'b00};
  localparam logic [31:0] MISC_A = {24'h000000, MISC_IDX, 2'b00};
  localparam logic [31:0] DAC_A  = {24'h000000, DAC1_REQ_IDX, 2'b00};
  logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans, dzc, pend;
  logic [2:0]        hsize;
  logic              pd_n, gcp, ame, ace, lmm, rmm, mim, gmm, mom, hpm, hps, sim;
  logic [GAIN_W-1:0] lmg, rmg, mig;
  logic [15:0]       dac1, dac2, seed, v, mic_s, misc_s;
  int                n_mismatch, cmp_count, cyc, i, k;
  assign hready = hreadyout;
  mcr_top #(.TIMEOUT_CYCLES(TMO)) i_mcr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .powerdown_pin_n(pd_n), .global_conversion_powerdown(gcp), .analog_mix_enable(ame),
    .analog_channels_enable(ace), .dac_zero_cross(dzc), .left_mic_mix_mute(lmm),
    .left_mic_mix_gain(lmg), .right_mic_mix_mute(rmm), .right_mic_mix_gain(rmg),
    .mono_in_mix_mute(mim), .mono_in_mix_gain(mig), .global_mix_mute(gmm),
    .mono_out_mute(mom), .headphone_mute(hpm), .headphone_swing_select(hps),
    .summing_input_mute(sim), .dac1_gain(dac1), .dac2_gain(dac2), .dac_gain_pending(pend));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] exp_mic(input logic [15:0] m, input logic [15:0] x);
    return {m[15] | x[7], m[12:8], m[7] | x[7], m[4:0]};
  endfunction
  function automatic logic [10:0] exp_misc(input logic [15:0] x);
    return {x[15] | x[7], x[12:8], x[7:4], x[3] | x[7]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // The address phase is held until hready is seen high, as the bus demands.
  task automatic bus(input logic [31:0] a, input logic w, input logic [15:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 16'h0000, x);
    chk("hrdata", e, x);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic chk_outs(input logic [15:0] m, input logic [15:0] x);
    chk("mic_outputs", exp_mic(m, x), {lmm, lmg, rmm, rmg});
    chk("misc_outputs", exp_misc(x), {mim, mig, gmm, mom, hpm, hps, sim});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hang in a bus wait ends here instead of running forever.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    hresetn = 1'b0; pd_n = 1'b1; gcp = 1'b0; ame = 1'b1; ace = 1'b1; dzc = 2'b00;
    seed = 16'h156E; n_mismatch = 0; cmp_count = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(MIC_A, 32'h00008888);
    rdchk(MISC_A, 32'h00008868);
    chk_outs(16'h8888, 16'h8868);
    $display("test reset_values done");
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed;
      seed = lfsr(seed);
      // Reserved bits are always written as zero by software.
      mic_s = v & MIC_WMASK;
      misc_s = (i == 0) ? MISC_WMASK : (seed & MISC_WMASK);
      wr(MIC_A, mic_s);
      wr(MISC_A, misc_s);
      rdchk(MIC_A, {16'h0000, mic_s});
      rdchk(MISC_A, {16'h0000, misc_s});
      chk_outs(mic_s, misc_s);
    end
    $display("test random_fields done");
    for (k = 0; k < 4; k++) begin
      wr(MIC_A, 16'h0000);
      wr(MISC_A, 16'h0000);
      pd_n <= (k != 0); gcp <= (k == 1); ame <= (k != 2); ace <= (k != 3);
      repeat (3) @(posedge hclk);
      wr(MIC_A, 16'h1F1F);
      wr(MISC_A, 16'h1F1B);
      rdchk(MIC_A, 32'h00008888);
      rdchk(MISC_A, (k < 2) ? 32'h00008868 : 32'h0000881B);
      chk_outs(16'h8888, (k < 2) ? 16'h8868 : 16'h881B);
      pd_n <= 1'b1; gcp <= 1'b0; ame <= 1'b1; ace <= 1'b1;
      rdchk(MIC_A, 32'h00008888);
    end
    $display("test hold_inputs done");
    for (k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      v = seed & 16'hBFBF;
      wr(MISC_A, 16'h0003);
      wr(DAC_A + 4 * k, v);
      repeat (4) @(posedge hclk);
      chk("dac_gain", v, k ? dac2 : dac1);
      wr(MISC_A, 16'h0000);
      wr(DAC_A + 4 * k, ~v & 16'hBFBF);
      repeat (4) @(posedge hclk);
      chk("dac_gain_held", v, k ? dac2 : dac1);
      chk("dac_gain_pending", 32'd1 << k, pend);
      rdchk(DAC_A + 8, 32'd1 << k);
      if (k == 0) begin
        dzc <= 2'b01;
        @(posedge hclk);
        dzc <= 2'b00;
        repeat (3) @(posedge hclk);
      end else begin
        repeat (TMO + 8) @(posedge hclk);
      end
      chk("dac_gain_new", ~v & 16'hBFBF, k ? dac2 : dac1);
      chk("dac_gain_pending", 32'h0, pend);
    end
    $display("test gain_timing done");
    wr(32'h00000100 | MIC_A, 16'h0000);
    rdchk(32'h00000100 | MIC_A, 32'h0);
    rdchk(MIC_A, 32'h00008888);
    $display("test unmapped done");
    give_verdict();
  end
endmodule
